// File: common/supervisor_map.svh
// Contract
// - reset held while supply low, then 100 ms
// - watchdog timeout programmable 100 ms to 3 s
// - enabled watchdog unrestarted pulses reset 100 ms
// - flag records cause of latest reset
// - reset output active low for all causes
// - manual reset filtered and debounced first
// - early fail input compared to 1.2 V
// - open-drain reset pin also senses manual reset
// - shared pin carries fail warning outside calibration
`ifndef SUPERVISOR_MAP_SVH
`define SUPERVISOR_MAP_SVH

`define CLK_KHZ 200000
`define STRETCH_MS 100
`define WD_UNIT_MS 100
`define DEB_US 10
`define CAL_HZ 512

`define OFS_CTRL 8'h00
`define OFS_RESTART 8'h04
`define OFS_STATUS 8'h08
`define OFS_TRIP 8'h0C

`define CTRL_WD_EN 0
`define CTRL_CAL 1
`define CTRL_SEL_LO 2
`define CTRL_SEL_HI 6
`define STAT_LOW 0
`define STAT_WD 1
`define STAT_MAN 2
`define STAT_ACTIVE 3
`define STAT_WARN 4
`define STAT_SUPLOW 5

`define WD_SEL_RST 5'h0A
`define WD_SEL_MIN 5'h01
`define WD_SEL_MAX 5'h1E
`define TRIP_RST 8'h80
`define REF_1V2 8'h60

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// File: common/supervisor_pkg.sv
package supervisor_pkg;

  typedef enum logic [1:0] {
    ST_RUN = 2'h0,
    ST_HOLD = 2'h1,
    ST_STRETCH = 2'h3
  } sup_state_t;

  typedef struct packed {
    sup_state_t st;
    logic [31:0] stretch_cnt;
    logic [31:0] wd_cnt;
    logic wd_en;
    logic cal_mode;
    logic [4:0] wd_sel;
    logic [7:0] trip;
    logic flag_low;
    logic flag_wd;
    logic flag_man;
    logic man_prev;
    logic [31:0] cal_cnt;
    logic cal_sq;
    logic fail_out;
    logic oe_n;
    logic aw_full;
    logic [7:0] aw_addr;
    logic w_full;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic aw_rdy;
    logic w_rdy;
    logic bvalid;
    logic [1:0] bresp;
    logic ar_rdy;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } sup_regs_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic [15:0] cnt;
    logic level;
  } deb_regs_t;

endpackage

// File: hw/pin_debounce.sv
`timescale 1ns/1ps
`include "supervisor_map.svh"

module pin_debounce #(
  parameter logic [15:0] STABLE_CYC = 16'(`DEB_US * `CLK_KHZ / 1000)
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic pin_i,
  output logic level_o
);

  supervisor_pkg::deb_regs_t r, n;

  always_comb begin
    n = r;
    n.s1 = pin_i;
    n.s2 = r.s1;
    n.s3 = r.s2;
    // glitches shorter than the window never reach the level
    if (r.s2 != r.s3 || r.s3 == r.level) begin
      n.cnt = 16'h0000;
    end else if (r.cnt == STABLE_CYC - 16'h0001) begin
      n.cnt = 16'h0000;
      n.level = r.s3;
    end else begin
      n.cnt = r.cnt + 16'h0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, cnt: 16'h0000, level: 1'b1};
    end else if (ce) begin
      r <= n;
    end
  end

  assign level_o = r.level;

  deb_hold_a: assert property (@(posedge aclk)
    disable iff (!aresetn || !ce) (r.s2 != r.s3) |=> $stable(r.level))
    else $error("debounced level moved on an unsettled input");

endmodule

// File: hw/processor_supervisor.sv
`timescale 1ns/1ps
`include "supervisor_map.svh"

module processor_supervisor #(
  parameter logic [31:0] STRETCH_CYC = 32'(`STRETCH_MS * `CLK_KHZ),
  parameter logic [31:0] WD_UNIT_CYC = 32'(`WD_UNIT_MS * `CLK_KHZ),
  parameter logic [31:0] CAL_HALF_CYC = 32'(`CLK_KHZ * 1000 / (2 * `CAL_HZ))
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [7:0] supply_code,
  input wire logic [7:0] early_fail_input,
  input wire logic rst_pin_i,
  output logic rst_pin_o,
  output logic rst_pin_oe_n,
  output logic calib_or_fail_warning_out,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp
);

  supervisor_pkg::sup_regs_t r, n;
  logic man_level;
  logic supply_low;
  logic wr_now;
  logic restart;
  logic man_fall;
  logic wd_expire;
  logic [4:0] sel_eff;
  logic [31:0] wd_limit;
  logic [7:0] waddr;
  logic [7:0] raddr;

  pin_debounce u_man_deb (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .pin_i(rst_pin_i),
    .level_o(man_level)
  );

  always_comb begin
    supply_low = supply_code < r.trip;
    if (r.wd_sel < `WD_SEL_MIN) begin
      sel_eff = `WD_SEL_MIN;
    end else if (r.wd_sel > `WD_SEL_MAX) begin
      sel_eff = `WD_SEL_MAX;
    end else begin
      sel_eff = r.wd_sel;
    end
    wd_limit = 32'(sel_eff) * WD_UNIT_CYC;
    waddr = {r.aw_addr[7:2], 2'h0};
    raddr = {s_axi_araddr[7:2], 2'h0};
    wr_now = r.aw_full && r.w_full && !r.bvalid;
    restart = wr_now && waddr == `OFS_RESTART && r.wstrb[0] &&
      r.wdata[0];
    // our own drive loops back on the pin, so only a run-state fall counts
    man_fall = r.man_prev && !man_level && r.st == supervisor_pkg::ST_RUN;
    wd_expire = r.st == supervisor_pkg::ST_RUN && r.wd_en &&
      r.wd_cnt >= wd_limit - 32'h1 && !restart;
  end

  always_comb begin
    n = r;
    n.man_prev = man_level;

    case (r.st)
      supervisor_pkg::ST_RUN: begin
        if (supply_low) begin
          n.st = supervisor_pkg::ST_HOLD;
          {n.flag_low, n.flag_wd, n.flag_man} = 3'h4;
        end else if (wd_expire) begin
          n.st = supervisor_pkg::ST_STRETCH;
          n.stretch_cnt = 32'h0;
          {n.flag_low, n.flag_wd, n.flag_man} = 3'h2;
        end else if (man_fall) begin
          n.st = supervisor_pkg::ST_STRETCH;
          n.stretch_cnt = 32'h0;
          {n.flag_low, n.flag_wd, n.flag_man} = 3'h1;
        end
      end
      supervisor_pkg::ST_HOLD: begin
        if (!supply_low) begin
          n.st = supervisor_pkg::ST_STRETCH;
          n.stretch_cnt = 32'h0;
        end
      end
      supervisor_pkg::ST_STRETCH: begin
        if (supply_low) begin
          n.st = supervisor_pkg::ST_HOLD;
          {n.flag_low, n.flag_wd, n.flag_man} = 3'h4;
        end else if (r.stretch_cnt == STRETCH_CYC - 32'h1) begin
          n.st = supervisor_pkg::ST_RUN;
        end else begin
          n.stretch_cnt = r.stretch_cnt + 32'h1;
        end
      end
      default: begin
        n.st = supervisor_pkg::ST_HOLD;
      end
    endcase

    // open drain: enable low pulls the pin low in every reset state
    n.oe_n = n.st == supervisor_pkg::ST_RUN;

    if (n.st != supervisor_pkg::ST_RUN || !r.wd_en || restart) begin
      n.wd_cnt = 32'h0;
    end else begin
      n.wd_cnt = r.wd_cnt + 32'h1;
    end

    if (r.cal_cnt == CAL_HALF_CYC - 32'h1) begin
      n.cal_cnt = 32'h0;
      n.cal_sq = !r.cal_sq;
    end else begin
      n.cal_cnt = r.cal_cnt + 32'h1;
    end
    n.fail_out = r.cal_mode ? r.cal_sq :
      (early_fail_input < `REF_1V2);

    if (s_axi_awvalid && r.aw_rdy) begin
      n.aw_full = 1'b1;
      n.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && r.w_rdy) begin
      n.w_full = 1'b1;
      n.wdata = s_axi_wdata;
      n.wstrb = s_axi_wstrb;
    end
    if (r.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (wr_now) begin
      n.aw_full = 1'b0;
      n.w_full = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = `RESP_OKAY;
      case (waddr)
        `OFS_CTRL: begin
          if (r.wstrb[0]) begin
            n.wd_en = r.wdata[`CTRL_WD_EN];
            n.cal_mode = r.wdata[`CTRL_CAL];
            n.wd_sel = r.wdata[`CTRL_SEL_HI:`CTRL_SEL_LO];
          end
        end
        `OFS_RESTART: begin
        end
        `OFS_STATUS: begin
          // a cause landing this cycle wins over the clear
          if (r.wstrb[0]) begin
            n.flag_low = n.flag_low & !(r.wdata[`STAT_LOW] &&
              !(supply_low && r.st != supervisor_pkg::ST_HOLD));
            n.flag_wd = n.flag_wd & !(r.wdata[`STAT_WD] && !wd_expire);
            n.flag_man = n.flag_man & !(r.wdata[`STAT_MAN] &&
              !(man_fall && !supply_low && !wd_expire));
          end
        end
        `OFS_TRIP: begin
          if (r.wstrb[0]) begin
            n.trip = r.wdata[7:0];
          end
        end
        default: begin
          n.bresp = `RESP_SLVERR;
        end
      endcase
    end
    n.aw_rdy = !n.aw_full && !n.bvalid;
    n.w_rdy = !n.w_full && !n.bvalid;

    if (r.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid && r.ar_rdy) begin
      n.rvalid = 1'b1;
      n.rresp = `RESP_OKAY;
      n.rdata = 32'h0;
      case (raddr)
        `OFS_CTRL: begin
          n.rdata[`CTRL_WD_EN] = r.wd_en;
          n.rdata[`CTRL_CAL] = r.cal_mode;
          n.rdata[`CTRL_SEL_HI:`CTRL_SEL_LO] = r.wd_sel;
        end
        `OFS_RESTART: begin
        end
        `OFS_STATUS: begin
          n.rdata[`STAT_LOW] = r.flag_low;
          n.rdata[`STAT_WD] = r.flag_wd;
          n.rdata[`STAT_MAN] = r.flag_man;
          n.rdata[`STAT_ACTIVE] = r.st != supervisor_pkg::ST_RUN;
          n.rdata[`STAT_WARN] = early_fail_input < `REF_1V2;
          n.rdata[`STAT_SUPLOW] = supply_low;
        end
        `OFS_TRIP: begin
          n.rdata[7:0] = r.trip;
        end
        default: begin
          n.rresp = `RESP_SLVERR;
        end
      endcase
    end
    n.ar_rdy = !n.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
      r.st <= supervisor_pkg::ST_STRETCH;
      r.wd_sel <= `WD_SEL_RST;
      r.trip <= `TRIP_RST;
      r.flag_low <= 1'b1;
      r.man_prev <= 1'b1;
      r.aw_rdy <= 1'b1;
      r.w_rdy <= 1'b1;
      r.ar_rdy <= 1'b1;
    end else if (ce) begin
      r <= n;
    end
  end

  assign rst_pin_o = 1'b0;
  assign rst_pin_oe_n = r.oe_n;
  assign calib_or_fail_warning_out = r.fail_out;
  assign s_axi_awready = r.aw_rdy;
  assign s_axi_wready = r.w_rdy;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_arready = r.ar_rdy;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;

  default clocking sva_cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn || !ce);

  low_supply_a: assert property (
    supply_low |=> (r.st == supervisor_pkg::ST_HOLD && !rst_pin_oe_n))
    else $error("low supply did not hold reset");

  stretch_end_a: assert property (
    (r.st == supervisor_pkg::ST_STRETCH && !supply_low &&
     r.stretch_cnt == STRETCH_CYC - 32'h1) |=>
    (r.st == supervisor_pkg::ST_RUN && rst_pin_oe_n))
    else $error("reset stretch did not end on time");

  wd_range_a: assert property (
    r.wd_cnt < WD_UNIT_CYC * 32'h1E)
    else $error("watchdog count beyond longest period");

  wd_fire_a: assert property (
    (wd_expire && !supply_low) |=>
    (r.st == supervisor_pkg::ST_STRETCH && r.stretch_cnt == 32'h0 &&
     !rst_pin_oe_n))
    else $error("watchdog expiry did not start a reset pulse");

  cause_flag_a: assert property (
    $rose(r.flag_wd) |-> $past(wd_expire) && !r.flag_low && !r.flag_man)
    else $error("watchdog flag set without its cause");

  pin_low_a: assert property (
    (r.st != supervisor_pkg::ST_RUN) |-> (!rst_pin_oe_n && !rst_pin_o))
    else $error("reset state without pin driven low");

  manual_ev_a: assert property (
    (man_fall && !supply_low && !wd_expire) |=>
    (r.st == supervisor_pkg::ST_STRETCH && r.flag_man))
    else $error("manual reset not taken");

  warn_out_a: assert property (
    (!r.cal_mode && early_fail_input < `REF_1V2) |=> r.fail_out)
    else $error("fail warning missing outside calibration");

  restart_clr_a: assert property (
    restart |=> r.wd_cnt == 32'h0)
    else $error("restart did not clear watchdog count");

endmodule

// File: sim/host_model.sv
`timescale 1ns/1ps
module host_model (
  input wire logic rst_pin_o,
  input wire logic rst_pin_oe_n,
  input wire logic press,
  output logic rst_level
);
  // weak pull-up: high unless the device or the button pulls low
  assign rst_level = ~rst_pin_oe_n ? rst_pin_o : ~press;
endmodule

// File: sim/processor_supervisor_tb_top.sv
`timescale 1ns/1ps
`include "supervisor_map.svh"
module processor_supervisor_tb_top;
  localparam int STR = 50;
  logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, press = 1'b0;
  logic [7:0] supply_code = 8'hFF, early = 8'hFF;
  logic rst_level, rst_pin_o, rst_pin_oe_n, calib;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r;
  int error_cnt = 0, total_checks = 0, n, i;
  initial forever #2.5 aclk = ~aclk;
  processor_supervisor #(.STRETCH_CYC(32'd50), .WD_UNIT_CYC(32'd40),
    .CAL_HALF_CYC(32'd8)) uut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .supply_code(supply_code), .early_fail_input(early),
    .rst_pin_i(rst_level), .rst_pin_o(rst_pin_o),
    .rst_pin_oe_n(rst_pin_oe_n), .calib_or_fail_warning_out(calib),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp));
  host_model host (.rst_pin_o(rst_pin_o), .rst_pin_oe_n(rst_pin_oe_n),
    .press(press), .rst_level(rst_level));
  task automatic final_report();
    if (error_cnt == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rng(input string nm, input int v, lo, hi);
    check(nm, 32'(v >= lo && v <= hi), 32'h1);
  endtask
  task automatic timeout(input int k, lim);
    if (k >= lim) begin
      check("timeout", 32'h0, 32'h1);
      final_report();
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
    int k;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    bready <= 1'b0;
    timeout(k, 50);
    check("bresp", 32'(bresp), 32'(`RESP_OKAY));
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v,
      output logic [1:0] rs);
    int k;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
    timeout(k, 50);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
      input string nm);
    axi_rd(a, d, r);
    check(nm, d, e);
  endtask
  // counts edges until the pin enable reaches v
  task automatic wait_oe(input logic v, input int lim, output int k);
    k = 0;
    while (rst_pin_oe_n !== v && k < lim) begin
      @(posedge aclk);
      k++;
    end
    timeout((rst_pin_oe_n !== v) ? lim : 0, lim);
  endtask
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    wait_oe(1'b1, 200, n);
    rng("pwrup_len", n, STR - 2, STR + 3);
    rd_chk(`OFS_STATUS, 32'h01, "stat_pwr");
    rd_chk(`OFS_TRIP, 32'h80, "trip_rst");
    rd_chk(`OFS_CTRL, 32'h28, "ctrl_rst");
    axi_rd(8'h10, d, r);
    check("unmapped", 32'(r), 32'(`RESP_SLVERR));
    // shortest timeout: one unit, restarted well before it runs out
    axi_wr(`OFS_CTRL, 32'h05);
    for (i = 0; i < 4; i++) begin
      repeat (25) @(posedge aclk);
      axi_wr(`OFS_RESTART, 32'h1);
    end
    check("wd_quiet", 32'(rst_pin_oe_n), 32'h1);
    wait_oe(1'b0, 100, n);
    rng("wd_fire", n, 33, 42);
    wait_oe(1'b1, 200, n);
    rng("wd_pulse", n, STR - 1, STR + 2);
    axi_wr(`OFS_CTRL, 32'h00);
    rd_chk(`OFS_STATUS, 32'h02, "stat_wd");
    // a short press must be filtered out
    press <= 1'b1;
    repeat (100) @(posedge aclk);
    press <= 1'b0;
    repeat (2100) @(posedge aclk);
    check("glitch", 32'(rst_pin_oe_n), 32'h1);
    press <= 1'b1;
    wait_oe(1'b0, 2200, n);
    rng("man_delay", n, 2000, 2010);
    press <= 1'b0;
    wait_oe(1'b1, 200, n);
    rd_chk(`OFS_STATUS, 32'h04, "stat_man");
    axi_wr(`OFS_TRIP, 32'h90);
    rd_chk(`OFS_TRIP, 32'h90, "trip_wr");
    supply_code <= 8'h90;
    repeat (5) @(posedge aclk);
    check("at_trip", 32'(rst_pin_oe_n), 32'h1);
    supply_code <= 8'h8F;
    wait_oe(1'b0, 5, n);
    repeat (3 * STR) @(posedge aclk);
    rd_chk(`OFS_STATUS, 32'h29, "stat_hold");
    check("hold", 32'(rst_pin_oe_n), 32'h0);
    // enable low freezes the hold even once the supply recovers
    ce <= 1'b0;
    supply_code <= 8'hFF;
    repeat (100) @(posedge aclk);
    check("ce_hold", 32'(rst_pin_oe_n), 32'h0);
    ce <= 1'b1;
    wait_oe(1'b1, 200, n);
    rng("sup_stretch", n, STR, STR + 3);
    rd_chk(`OFS_STATUS, 32'h01, "stat_low");
    axi_wr(`OFS_STATUS, 32'h07);
    rd_chk(`OFS_STATUS, 32'h00, "stat_clr");
    early <= 8'h5F;
    repeat (4) @(posedge aclk);
    check("warn_on", 32'(calib), 32'h1);
    rd_chk(`OFS_STATUS, 32'h10, "stat_warn");
    early <= 8'h60;
    repeat (4) @(posedge aclk);
    check("warn_off", 32'(calib), 32'h0);
    // reset in mid-run restarts the pulse and the low-supply flag
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    wait_oe(1'b1, 200, n);
    rng("rerst_len", n, STR - 2, STR + 3);
    rd_chk(`OFS_STATUS, 32'h01, "stat_rerst");
    axi_wr(`OFS_CTRL, 32'h02);
    // one settling edge so the mode switch itself is not counted
    @(posedge aclk);
    d[0] = calib;
    n = 0;
    for (i = 0; i < 128; i++) begin
      @(posedge aclk);
      if (calib !== d[0]) n++;
      d[0] = calib;
    end
    rng("cal_wave", n, 15, 17);
    final_report();
  end
endmodule
